// ### bench/iepc_core_model.sv
// partner: core that takes a requested irq into service
`timescale 1ns/10ps
module iepc_core_model (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [31:0] irq_req,
  input  wire logic        take,
  input  wire logic        done,
  output logic      [31:0] irq_ack,
  output logic      [31:0] irq_active
);
  // ========
  // lowest requested irq: one-cycle ack, then active until done
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_ack <= 32'h0;
      irq_active <= 32'h0;
    end else begin
      irq_ack <= (take && irq_active == 32'h0) ? (irq_req & (~irq_req + 32'h1)) : 32'h0;
      irq_active <= done ? 32'h0 : (irq_active | irq_ack);
    end
  end
endmodule // iepc_core_model

// ### bench/iepc_sva.sv
// checker: port properties of the irq enable/pending block
`timescale 1ns/10ps
module iepc_sva (
  input wire logic                       ref_clk,
  input wire logic                       rst_b,
  input wire logic                       clk_en,
  input wire iepc_pkg::iepc_ahb_in_type  ahb_in,
  input wire iepc_pkg::iepc_ahb_out_type ahb_out,
  input wire logic [31:0]                irq_src,
  input wire logic [31:0]                irq_ack,
  input wire logic [31:0]                irq_active,
  input wire logic [31:0]                irq_req
);
  // ========
  // helpers
  logic        tk;
  logic        dph_r;
  logic [31:0] unp_c;
  logic [31:0] keep_c;
  logic [31:0] ack_c;
  // transfer taken and masks of bits that must drop or stay
  assign tk = ahb_in.hsel & ahb_in.htrans[1] & ahb_in.hready & clk_en;
  assign unp_c = ahb_in.hwdata & ~irq_src & ~irq_active;
  assign keep_c = irq_req & ahb_in.hwdata & irq_active & ~irq_ack;
  assign ack_c = irq_ack & ~irq_src;
  // marks the data phase of a taken write
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) dph_r <= 1'b0;
    else dph_r <= tk & ahb_in.hwrite;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // word write taken at ofs, then its data phase runs
  sequence sq_wr(logic [7:0] ofs);
    tk && ahb_in.hwrite && ahb_in.haddr[7:0] == ofs && ahb_in.hsize == 3'h2 ##1 clk_en;
  endsequence
  // ========
  // properties
  AST_OKAY: assert property (ahb_out.hresp == 1'h0 && ahb_out.hreadyout == 1'h1)
    else $error("bus answer not ready okay");
  AST_DIS: assert property (sq_wr(8'h00) |=> (irq_req & $past(ahb_in.hwdata)) == 32'h0)
    else $error("disabled irq still requested");
  AST_UNPEND: assert property (sq_wr(8'h08) |=> (irq_req & $past(unp_c)) == 32'h0)
    else $error("clear-pending left request");
  AST_KEEP: assert property (sq_wr(8'h08) |=> (~irq_req & $past(keep_c)) == 32'h0)
    else $error("in-service irq lost pending");
  AST_ACK: assert property (clk_en && !dph_r |=> (irq_req & $past(ack_c)) == 32'h0)
    else $error("acked irq still requested");
  AST_RDZ: assert property (tk && !ahb_in.hwrite && ahb_in.haddr[7:0] >= 8'h10
    |=> ahb_out.hrdata == 32'h0) else $error("unmapped read not zero");
  AST_HOLD: assert property (!(tk && !ahb_in.hwrite) |=> $stable(ahb_out.hrdata))
    else $error("read data moved without read");
  AST_FRZ: assert property (!clk_en |=> $stable(irq_req))
    else $error("request moved while frozen");
  AST_RISE: assert property ((irq_req & ~$past(irq_req) & ~$past(irq_src)) != 32'h0
    |-> $past(dph_r)) else $error("request rose without cause");
endmodule // iepc_sva

bind iepc_top iepc_sva u_sva (.ref_clk, .rst_b, .clk_en, .ahb_in, .ahb_out, .irq_src,
  .irq_ack, .irq_active, .irq_req);

// ### bench/iepc_tb_top.sv
// testbench: register table, service entry and freeze of the irq block
`timescale 1ns/10ps
module iepc_tb_top;
  // ========
  // signals
  typedef struct packed {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [7:0]  ra;
    logic [31:0] rd;
    logic [31:0] rq;
  } iepc_row_type;
  logic                       ref_clk = 1'b0;
  logic                       rst_b = 1'b0;
  logic                       clk_en = 1'b1;
  logic                       take = 1'b0;
  logic                       done = 1'b0;
  logic [31:0]                src = 32'h0;
  logic [31:0]                q;
  logic [31:0]                ack;
  logic [31:0]                act;
  logic [31:0]                req;
  iepc_pkg::iepc_ahb_in_type  m = '{hsize: 3'h2, default: '0};
  iepc_pkg::iepc_ahb_out_type ao;
  int                         fail_count = 0;
  int                         check_count = 0;
  iepc_row_type               rows [6] = '{
    '{8'h0c, 32'hffff_ffff, 8'h00, 32'hffff_ffff, 32'h0},
    '{8'h00, 32'h0000_00f0, 8'h0c, 32'hffff_ff0f, 32'h0},
    '{8'h04, 32'h0000_00ff, 8'h04, 32'h0000_000f, 32'h0000_000f},
    '{8'h04, 32'h0000_0003, 8'h08, 32'h0000_000f, 32'h0000_000f},
    '{8'h08, 32'h0000_0003, 8'h04, 32'h0000_000c, 32'h0000_000c},
    '{8'h20, 32'hffff_ffff, 8'h20, 32'h0, 32'h0000_000c}};
  always #2.5 ref_clk = ~ref_clk;
  iepc_top dut (.ref_clk, .rst_b, .clk_en,
    .ahb_in(iepc_pkg::iepc_ahb_in_type'({m[71:1], ao.hreadyout})), .ahb_out(ao),
    .irq_src(src), .irq_ack(ack), .irq_active(act), .irq_req(req));
  iepc_core_model u_core (.ref_clk, .rst_b, .irq_req(req), .take, .done, .irq_ack(ack),
    .irq_active(act));
  // ========
  // tasks
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one bus phase: wait for ready under a bound
  task automatic hold;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ao.hreadyout !== 1'b1 && n < 64);
    if (n >= 64) begin
      fail_count++;
      results();
    end
  endtask
  task automatic xf(input logic [7:0] a, input logic w, input logic [31:0] d);
    m.hsel <= 1'b1;
    m.haddr <= {24'h0, a};
    m.htrans <= 2'h2;
    m.hwrite <= w;
    hold();
    m.htrans <= 2'h0;
    m.hwdata <= d;
    hold();
    q = ao.hrdata;
  endtask
  // ========
  // main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    xf(8'h00, 1'b0, 32'h0);
    chk("enable reset", q, 32'h0);
    xf(8'h04, 1'b0, 32'h0);
    chk("pending reset", q, 32'h0);
    foreach (rows[i]) begin
      xf(rows[i].wa, 1'b1, rows[i].wd);
      xf(rows[i].ra, 1'b0, 32'h0);
      chk("row read", q, rows[i].rd);
      chk("row req", req, rows[i].rq);
    end
    take <= 1'b1;
    @(posedge ref_clk);
    take <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("req after ack", req, 32'h0000_0008);
    src <= 32'h0000_0004;
    @(posedge ref_clk);
    src <= 32'h0;
    xf(8'h08, 1'b1, 32'h0000_000c);
    xf(8'h04, 1'b0, 32'h0);
    chk("served kept", q, 32'h0000_0004);
    done <= 1'b1;
    @(posedge ref_clk);
    done <= 1'b0;
    xf(8'h08, 1'b1, 32'h0000_0004);
    xf(8'h08, 1'b0, 32'h0);
    chk("unpend", q, 32'h0);
    clk_en <= 1'b0;
    xf(8'h04, 1'b1, 32'h0000_0001);
    clk_en <= 1'b1;
    xf(8'h04, 1'b0, 32'h0);
    chk("frozen pend", q, 32'h0);
    rst_b <= 1'b0;
    @(posedge ref_clk);
    rst_b <= 1'b1;
    xf(8'h00, 1'b0, 32'h0);
    chk("enable after reset", q, 32'h0);
    chk("req after reset", req, 32'h0);
    results();
  end
endmodule // iepc_tb_top

// ### rtl/iepc_top.sv
// module: per-interrupt enable and pending bookkeeping behind an ahb-lite slave
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps

module iepc_top (
  input  wire logic                                  ref_clk,
  input  wire logic                                  rst_b,
  input  wire logic                                  clk_en,
  input  wire iepc_pkg::iepc_ahb_in_type             ahb_in,
  output iepc_pkg::iepc_ahb_out_type                 ahb_out,
  input  wire logic [iepc_pkg::IEPC_NUM_IRQ-1:0]     irq_src,
  input  wire logic [iepc_pkg::IEPC_NUM_IRQ-1:0]     irq_ack,
  input  wire logic [iepc_pkg::IEPC_NUM_IRQ-1:0]     irq_active,
  output logic      [iepc_pkg::IEPC_NUM_IRQ-1:0]     irq_req
);

  // ==========================================================================
  // address decode, shared by the read path and the write capture
  function automatic iepc_pkg::iepc_reg_type iepc_decode(
    input logic [iepc_pkg::IEPC_ADDR_W-1:0] addr
  );
    iepc_pkg::iepc_reg_type sel;
    sel = iepc_pkg::IEPC_REG_NONE;
    unique case (addr)
      iepc_pkg::IEPC_OFS_DISABLE:    sel = iepc_pkg::IEPC_REG_DISABLE;
      iepc_pkg::IEPC_OFS_PEND_SET:   sel = iepc_pkg::IEPC_REG_PEND_SET;
      iepc_pkg::IEPC_OFS_UNPEND:     sel = iepc_pkg::IEPC_REG_UNPEND;
      iepc_pkg::IEPC_OFS_ENABLE_SET: sel = iepc_pkg::IEPC_REG_ENABLE_SET;
      default:                       sel = iepc_pkg::IEPC_REG_NONE;
    endcase
    return sel;
  endfunction

  // ==========================================================================
  // state
  iepc_pkg::iepc_state_type st_r;
  iepc_pkg::iepc_state_type st_nxt;

  // ==========================================================================
  // address phase qualification
  logic                   addr_take;
  logic                   word_ok;
  iepc_pkg::iepc_reg_type addr_reg;

  // a transfer is taken when selected, active and the bus is ready
  assign addr_take = ahb_in.hsel
                   & ahb_in.htrans[iepc_pkg::IEPC_HTRANS_ACT_BIT]
                   & ahb_in.hready;
  assign word_ok   = (ahb_in.hsize == iepc_pkg::IEPC_HSIZE_WORD);
  assign addr_reg  = iepc_decode(ahb_in.haddr[iepc_pkg::IEPC_ADDR_W-1:0]);

  // ==========================================================================
  // next-state logic
  always_comb begin
    logic [iepc_pkg::IEPC_NUM_IRQ-1:0] wdata;
    logic [iepc_pkg::IEPC_NUM_IRQ-1:0] en_clr;
    logic [iepc_pkg::IEPC_NUM_IRQ-1:0] en_set;
    logic [iepc_pkg::IEPC_NUM_IRQ-1:0] pd_clr;
    logic [iepc_pkg::IEPC_NUM_IRQ-1:0] pd_set;
    logic [iepc_pkg::IEPC_NUM_IRQ-1:0] sw_pend;
    iepc_pkg::iepc_reg_type            rd_sel;
    wdata   = ahb_in.hwdata[iepc_pkg::IEPC_NUM_IRQ-1:0];
    en_clr  = '0;
    en_set  = '0;
    pd_clr  = '0;
    pd_set  = '0;
    sw_pend = '0;
    rd_sel  = iepc_pkg::IEPC_REG_NONE;
    st_nxt  = st_r;

    // write data phase: one-bits act (pend-set only on enabled bits, unpend only on inactive ones), zero-bits leave state alone
    if (st_r.wr_pend) begin
      unique case (st_r.wr_reg)
        iepc_pkg::IEPC_REG_DISABLE: begin
          en_clr = wdata;
        end
        iepc_pkg::IEPC_REG_ENABLE_SET: begin
          en_set = wdata;
        end
        iepc_pkg::IEPC_REG_PEND_SET: begin
          sw_pend = wdata & st_r.enable & ~st_r.pending;
        end
        iepc_pkg::IEPC_REG_UNPEND: begin
          pd_clr = wdata & ~irq_active;
        end
        iepc_pkg::IEPC_REG_NONE: begin
          en_clr = '0;
        end
        default: begin
          en_clr = '0;
        end
      endcase
    end

    // hardware sources and software forcing both set the pending bit
    pd_set = irq_src | sw_pend;

    // entry into service also clears the pending bit
    pd_clr = pd_clr | irq_ack;

    // per-interrupt bookkeeping, bit n belongs to interrupt n
    st_nxt.enable  = (st_r.enable & ~en_clr) | en_set;
    st_nxt.pending = (st_r.pending & ~pd_clr) | pd_set;

    // request only for enabled pending interrupts
    st_nxt.req = st_nxt.pending & st_nxt.enable;

    // capture a write for its data phase
    st_nxt.wr_pend = addr_take & ahb_in.hwrite & word_ok;
    st_nxt.wr_reg  = addr_reg;

    // read data, taken from the updated state so a preceding write shows
    if (addr_take & ~ahb_in.hwrite) begin
      rd_sel = addr_reg;
    end
    unique case (rd_sel)
      iepc_pkg::IEPC_REG_DISABLE: begin
        st_nxt.hrdata = st_nxt.enable;
      end
      iepc_pkg::IEPC_REG_ENABLE_SET: begin
        st_nxt.hrdata = st_nxt.enable;
      end
      iepc_pkg::IEPC_REG_PEND_SET: begin
        st_nxt.hrdata = st_nxt.pending;
      end
      iepc_pkg::IEPC_REG_UNPEND: begin
        st_nxt.hrdata = st_nxt.pending;
      end
      iepc_pkg::IEPC_REG_NONE: begin
        // unmapped reads return zero; with no read taken the last read data stands
        st_nxt.hrdata = (addr_take & ~ahb_in.hwrite) ? iepc_pkg::IEPC_RDATA_ZERO
                                                     : st_r.hrdata;
      end
      default: begin
        st_nxt.hrdata = iepc_pkg::IEPC_RDATA_ZERO;
      end
    endcase

    // zero wait states, always okay
    st_nxt.hreadyout = iepc_pkg::IEPC_HREADY_ON;
    st_nxt.hresp     = iepc_pkg::IEPC_HRESP_OKAY;
  end

  // ==========================================================================
  // state register, frozen while the clock enable is low
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r.enable    <= iepc_pkg::IEPC_RST_ENABLE;
      st_r.pending   <= iepc_pkg::IEPC_RST_PENDING;
      st_r.req       <= iepc_pkg::IEPC_RST_PENDING;
      st_r.hrdata    <= iepc_pkg::IEPC_RST_RDATA;
      st_r.hreadyout <= iepc_pkg::IEPC_HREADY_ON;
      st_r.hresp     <= iepc_pkg::IEPC_HRESP_OKAY;
      st_r.wr_pend   <= 1'h0;
      st_r.wr_reg    <= iepc_pkg::IEPC_REG_NONE;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // outputs straight from the state register
  assign ahb_out.hrdata    = st_r.hrdata;
  assign ahb_out.hreadyout = st_r.hreadyout;
  assign ahb_out.hresp     = st_r.hresp;
  assign irq_req           = st_r.req;

endmodule // iepc_top

// ### shared/iepc_pkg.sv
// package: constants, register map and carrier types of the irq enable/pending block
package iepc_pkg;

  // ==========================================================================
  // sizes
  localparam int unsigned IEPC_NUM_IRQ = 32;
  localparam int unsigned IEPC_ADDR_W  = 8;

  // ==========================================================================
  // register byte offsets within the slave window
  localparam logic [IEPC_ADDR_W-1:0] IEPC_OFS_DISABLE    = 8'h00;
  localparam logic [IEPC_ADDR_W-1:0] IEPC_OFS_PEND_SET   = 8'h04;
  localparam logic [IEPC_ADDR_W-1:0] IEPC_OFS_UNPEND     = 8'h08;
  localparam logic [IEPC_ADDR_W-1:0] IEPC_OFS_ENABLE_SET = 8'h0c;

  // ==========================================================================
  // reset values
  localparam logic [IEPC_NUM_IRQ-1:0] IEPC_RST_ENABLE  = 32'h0000_0000;
  localparam logic [IEPC_NUM_IRQ-1:0] IEPC_RST_PENDING = 32'h0000_0000;
  localparam logic [31:0]             IEPC_RST_RDATA   = 32'h0000_0000;
  localparam logic [31:0]             IEPC_RDATA_ZERO  = 32'h0000_0000;

  // ==========================================================================
  // ahb-lite encodings
  localparam int unsigned IEPC_HTRANS_ACT_BIT = 1;
  localparam logic [2:0]  IEPC_HSIZE_WORD     = 3'h2;
  localparam logic        IEPC_HRESP_OKAY     = 1'h0;
  localparam logic        IEPC_HREADY_ON      = 1'h1;

  // ==========================================================================
  // register selected by a transfer
  typedef enum logic [2:0] {
    IEPC_REG_NONE       = 3'h0,
    IEPC_REG_DISABLE    = 3'h1,
    IEPC_REG_PEND_SET   = 3'h2,
    IEPC_REG_UNPEND     = 3'h3,
    IEPC_REG_ENABLE_SET = 3'h4
  } iepc_reg_type;

  // ==========================================================================
  // ahb-lite slave inputs and outputs
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } iepc_ahb_in_type;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } iepc_ahb_out_type;

  // ==========================================================================
  // complete state of the block
  typedef struct packed {
    logic [IEPC_NUM_IRQ-1:0] enable;
    logic [IEPC_NUM_IRQ-1:0] pending;
    logic [IEPC_NUM_IRQ-1:0] req;
    logic [31:0]             hrdata;
    logic                    hreadyout;
    logic                    hresp;
    logic                    wr_pend;
    iepc_reg_type            wr_reg;
  } iepc_state_type;

endpackage
